// ---- dpbs_pkg.sv ----
// Constants for the burst memory port with separate read and write data ports
package dpbs_pkg;
    localparam int          DPBS_LANE_W     = 9;
    localparam int          DPBS_ORG_W      = 18;
    localparam int          DPBS_AW_ORG18   = 19;
    localparam int          DPBS_AW_ORG36   = 18;
    localparam int          DPBS_BURST_LEN  = 4;
    localparam int          DPBS_BEAT_W     = 2;
    localparam logic [1:0]  DPBS_LAST_BEAT  = 2'h3;
    localparam int          DPBS_FIFO_DEPTH = 32;
    localparam int          DPBS_CLK_MHZ    = 50;

    typedef enum logic [4:0] {
        DPBS_RD_IDLE  = 5'b00001,
        DPBS_RD_FETCH = 5'b00010,
        DPBS_RD_WAIT  = 5'b00100,
        DPBS_RD_DRIVE = 5'b01000,
        DPBS_RD_TAIL  = 5'b10000
    } dpbs_rd_state_t;

    function automatic int dpbs_addr_w(input int data_w);
        return (data_w == DPBS_ORG_W) ? DPBS_AW_ORG18 : DPBS_AW_ORG36;
    endfunction

    function automatic int dpbs_lanes(input int data_w);
        return data_w / DPBS_LANE_W;
    endfunction
endpackage

// ---- dpbs_port.sv ----
// Burst memory port: pin capture, write buffer, storage array and read burst drive
`timescale 1ns/10ps

module dpbs_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [W-1:0]               in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [W-1:0]                    out_data,
    output logic [$clog2(DEPTH+1)-1:0]      level
);
    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);

    logic [W-1:0]  store [0:DEPTH-1];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [LW-1:0] cnt_r;
    wire           do_push = in_valid & in_ready;
    wire           do_pop  = out_valid & out_ready;

    assign in_ready  = (cnt_r != LW'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = store[rp_r];
    assign level     = cnt_r;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH-1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clk) begin
        if (do_push) begin
            store[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (do_push) begin
                wp_r <= ptr_inc(wp_r);
            end
            if (do_pop) begin
                rp_r <= ptr_inc(rp_r);
            end
            cnt_r <= cnt_r + LW'(do_push) - LW'(do_pop);
        end
    end
endmodule

module dpbs_port import dpbs_pkg::*; #(
    parameter int DATA_W  = DPBS_ORG_W,
    parameter int FIFO_DP = DPBS_FIFO_DEPTH
) (
    input  wire logic                               sys_clk,
    input  wire logic                               nrst,
    input  wire logic                               primary_timing_input,
    input  wire logic                               inverted_timing_input,
    input  wire logic [dpbs_addr_w(DATA_W)-1:0]     addr_in,
    input  wire logic [DATA_W-1:0]                  write_word_bus,
    input  wire logic [dpbs_lanes(DATA_W)-1:0]      byte_lane_write_select_n,
    input  wire logic                               read_port_select_n,
    input  wire logic                               write_port_select_n,
    output logic [DATA_W-1:0]                       output_word_bus,
    output logic                                    output_word_bus_oe_n
);
    localparam int AW    = dpbs_addr_w(DATA_W);
    localparam int LANES = dpbs_lanes(DATA_W);
    localparam int MAW   = AW + DPBS_BEAT_W;
    localparam int EW    = MAW + LANES + DATA_W;
    localparam int SW    = 4 + AW + DATA_W + LANES;
    // Idle pin levels: inverted clock, selects and lane selects high
    localparam logic [SW-1:0] PIN_IDLE = {1'b0, 1'b1, 1'b1, 1'b1, {AW{1'b0}}, {DATA_W{1'b0}},
                                          {LANES{1'b1}}};

    // Two-stage pin capture
    logic [SW-1:0] pin_s1_r;
    logic [SW-1:0] pin_s2_r;
    logic          k_s3_r;
    logic          kb_s3_r;
    wire  [SW-1:0] pin_raw = {primary_timing_input, inverted_timing_input, read_port_select_n,
                              write_port_select_n, addr_in, write_word_bus,
                              byte_lane_write_select_n};
    wire             k_s     = pin_s2_r[SW-1];
    wire             kb_s    = pin_s2_r[SW-2];
    wire             rps_n_s = pin_s2_r[SW-3];
    wire             wps_n_s = pin_s2_r[SW-4];
    wire [AW-1:0]    addr_s  = pin_s2_r[AW+DATA_W+LANES-1:DATA_W+LANES];
    wire [DATA_W-1:0] d_s    = pin_s2_r[DATA_W+LANES-1:LANES];
    wire [LANES-1:0] bws_n_s = pin_s2_r[LANES-1:0];
    wire             k_rise  = k_s & ~k_s3_r;
    wire             kb_rise = kb_s & ~kb_s3_r;
    wire             any_edge = k_rise | kb_rise;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_r <= PIN_IDLE;
            pin_s2_r <= PIN_IDLE;
            k_s3_r   <= 1'b0;
            kb_s3_r  <= 1'b1;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            k_s3_r   <= k_s;
            kb_s3_r  <= kb_s;
        end
    end

    // Storage array
    logic [DATA_W-1:0] mem [0:(2**MAW)-1];
    logic [DATA_W-1:0] mem_rd_r;

    // Read control
    dpbs_rd_state_t    rd_state_r;
    dpbs_rd_state_t    rd_state_nxt;
    logic [AW-1:0]     rd_addr_r;
    logic [2:0]        fcnt_r;
    logic [1:0]        rbeat_r;
    logic [DATA_W-1:0] rbuf_r [0:DPBS_BURST_LEN-1];
    logic [DATA_W-1:0] q_r;
    logic              q_oe_n_r;

    wire rd_idle  = (rd_state_r == DPBS_RD_IDLE);
    wire rd_start = k_rise & ~rps_n_s & rd_idle;
    wire fetching = (rd_state_r == DPBS_RD_FETCH);
    wire fetch_done = fetching & (fcnt_r == 3'(DPBS_BURST_LEN));
    wire drive_edge = (rd_state_r == DPBS_RD_DRIVE) & any_edge;
    wire wait_go  = (rd_state_r == DPBS_RD_WAIT) & k_rise;
    wire tail_go  = (rd_state_r == DPBS_RD_TAIL) & kb_rise;
    wire [MAW-1:0] rd_mem_a = {rd_addr_r, fcnt_r[1:0]};

    always_comb begin
        rd_state_nxt = rd_state_r;
        unique case (rd_state_r)
            DPBS_RD_IDLE:  if (rd_start) rd_state_nxt = DPBS_RD_FETCH;
            DPBS_RD_FETCH: if (fetch_done) rd_state_nxt = DPBS_RD_WAIT;
            DPBS_RD_WAIT:  if (wait_go) rd_state_nxt = DPBS_RD_DRIVE;
            DPBS_RD_DRIVE: if (drive_edge && rbeat_r == DPBS_LAST_BEAT) begin
                rd_state_nxt = DPBS_RD_TAIL;
            end
            DPBS_RD_TAIL:  if (tail_go) rd_state_nxt = DPBS_RD_IDLE;
            default:       rd_state_nxt = DPBS_RD_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_state_r <= DPBS_RD_IDLE;
            rd_addr_r  <= '0;
            fcnt_r     <= '0;
            rbeat_r    <= '0;
        end else begin
            rd_state_r <= rd_state_nxt;
            if (rd_start) begin
                rd_addr_r <= addr_s;
            end
            fcnt_r  <= fetching ? fcnt_r + 3'h1 : 3'h0;
            rbeat_r <= (wait_go | drive_edge) ? rbeat_r + 2'h1 : (rd_idle ? 2'h0 : rbeat_r);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (fetching && fcnt_r != 3'h0) begin
            rbuf_r[fcnt_r[1:0] - 2'h1] <= mem_rd_r;
        end
    end

    // Output word and driver enable
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            q_r      <= '0;
            q_oe_n_r <= 1'b1;
        end else begin
            if (wait_go || drive_edge) begin
                q_r <= rbuf_r[rbeat_r];
            end
            if (wait_go) begin
                q_oe_n_r <= 1'b0;
            end else if (tail_go) begin
                q_oe_n_r <= 1'b1;
            end
        end
    end

    assign output_word_bus      = q_r;
    assign output_word_bus_oe_n = q_oe_n_r;

    // Write capture
    logic          wr_act_r;
    logic [1:0]    wbeat_r;
    logic [AW-1:0] wr_addr_r;
    logic          push_ready;
    logic          pop_valid;
    logic [EW-1:0] pop_data;
    logic [$clog2(FIFO_DP+1)-1:0] fifo_level;

    wire wr_room  = (32'(fifo_level) <= FIFO_DP - DPBS_BURST_LEN) & push_ready;
    wire wr_start = k_rise & ~wps_n_s & ~wr_act_r & wr_room & ~rd_start;
    wire wr_beat  = wr_act_r & any_edge;
    wire push_valid = wr_start | wr_beat;
    wire [MAW-1:0] push_addr = wr_start ? {addr_s, 2'h0} : {wr_addr_r, wbeat_r};
    wire [EW-1:0]  push_data = {push_addr, bws_n_s, d_s};
    wire pop_ready = ~fetching;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_act_r  <= 1'b0;
            wbeat_r   <= '0;
            wr_addr_r <= '0;
        end else if (wr_start) begin
            wr_act_r  <= 1'b1;
            wbeat_r   <= 2'h1;
            wr_addr_r <= addr_s;
        end else if (wr_beat) begin
            wbeat_r  <= wbeat_r + 2'h1;
            wr_act_r <= (wbeat_r != DPBS_LAST_BEAT);
        end
    end

    dpbs_fifo #(
        .W     (EW),
        .DEPTH (FIFO_DP)
    ) u_wr_fifo (
        .clk       (sys_clk),
        .nrst      (nrst),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_data),
        .level     (fifo_level)
    );

    // Array write with lane masking, read port shared with fetch
    wire [MAW-1:0]    wm_addr = pop_data[EW-1:LANES+DATA_W];
    wire [LANES-1:0]  wm_bws_n = pop_data[LANES+DATA_W-1:DATA_W];
    wire [DATA_W-1:0] wm_data = pop_data[DATA_W-1:0];

    always_ff @(posedge sys_clk) begin
        mem_rd_r <= mem[rd_mem_a];
        if (pop_valid && pop_ready) begin
            for (int i = 0; i < LANES; i++) begin
                if (!wm_bws_n[i]) begin
                    mem[wm_addr][i*DPBS_LANE_W +: DPBS_LANE_W] <=
                        wm_data[i*DPBS_LANE_W +: DPBS_LANE_W];
                end
            end
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    logic [2:0] drv_cnt_r;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            drv_cnt_r <= '0;
        end else if (rd_idle) begin
            drv_cnt_r <= '0;
        end else if (wait_go || drive_edge) begin
            drv_cnt_r <= drv_cnt_r + 3'h1;
        end
    end

    // Beats pushed in the current write burst
    logic [2:0] wpush_cnt_r;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wpush_cnt_r <= '0;
        end else if (wr_start) begin
            wpush_cnt_r <= 3'h1;
        end else if (wr_beat) begin
            wpush_cnt_r <= wpush_cnt_r + 3'h1;
        end
    end

    sequence s_wr_cmd;
        k_rise && !wps_n_s && !wr_act_r && wr_room && !rd_start;
    endsequence
    sequence s_rd_cmd;
        k_rise && !rps_n_s && rd_idle;
    endsequence

    AST_WR_START: assert property (s_wr_cmd |=> wr_act_r && wbeat_r == 2'h1)
        else $error("write burst did not start");
    AST_WR_BEAT_PUSH: assert property (wr_act_r && any_edge |-> push_valid)
        else $error("write beat not captured");
    AST_LANE_SAME_EDGE: assert property (push_valid |-> push_data[EW-MAW-1:DATA_W] == bws_n_s
                                          && push_data[DATA_W-1:0] == d_s)
        else $error("lane selects not taken with data");
    AST_WR_FOUR_BEATS: assert property ($fell(wr_act_r) |-> wpush_cnt_r == 3'h4)
        else $error("write burst not four beats");
    AST_RD_ADDR: assert property (s_rd_cmd |=> fetching && rd_addr_r == $past(addr_s))
        else $error("read address not captured");
    AST_DESELECT_IGNORE: assert property (k_rise && rps_n_s && wps_n_s && rd_idle && !wr_act_r
                                          |=> rd_idle && !wr_act_r)
        else $error("deselected port took address");
    AST_IDLE_HIZ: assert property (rd_idle |-> output_word_bus_oe_n)
        else $error("bus driven while read idle");
    AST_BURST_FOUR: assert property (tail_go |-> drv_cnt_r == 3'h4)
        else $error("read burst not four words");
    AST_RELEASE: assert property (tail_go |=> output_word_bus_oe_n && rd_idle)
        else $error("drivers not released after tail");
    AST_FETCH_LEN: assert property (s_rd_cmd |=> fetching[*5] ##1 (rd_state_r == DPBS_RD_WAIT))
        else $error("fetch length wrong");
    AST_Q_BEAT: assert property (drive_edge |=> output_word_bus == $past(rbuf_r[rbeat_r])
                                 && !output_word_bus_oe_n)
        else $error("read beat word wrong");
endmodule

// ---- dpbs_ctl_model.sv ----
// Memory controller model: timing clocks, shared address, write beats, read capture
`timescale 1ns/10ps

module dpbs_ctl_model (
    input  wire logic          sys_clk,
    input  wire logic [17:0]   q,
    input  wire logic          q_oe_n,
    output logic               k,
    output logic               kb,
    output logic [18:0]        addr,
    output logic [17:0]        wdata,
    output logic [1:0]         bw_n,
    output logic               rps_n,
    output logic               wps_n
);
    logic [17:0] seen_q;
    logic        seen_oe_n;

    initial begin
        k     = 1'b0;
        kb    = 1'b1;
        addr  = 19'h00000;
        wdata = 18'h00000;
        bw_n  = 2'h3;
        rps_n = 1'b1;
        wps_n = 1'b1;
    end

    // One half period: pins set, held, clocks swap, held, bus sampled
    task automatic half(input logic [18:0] a, input logic [17:0] d, input logic [1:0] bw,
                        input logic rs, input logic ws);
        @(posedge sys_clk);
        #1;
        addr  = a;
        wdata = d;
        bw_n  = bw;
        rps_n = rs;
        wps_n = ws;
        repeat (5) @(posedge sys_clk);
        #1;
        k  = ~k;
        kb = ~kb;
        repeat (5) @(posedge sys_clk);
        #1;
        seen_q    = q;
        seen_oe_n = q_oe_n;
    endtask

    // Four beats, each with its own selects; address only valid on first
    task automatic write_burst(input logic [18:0] a, input logic [3:0][17:0] d,
                               input logic [3:0][1:0] bw);
        for (int n = 0; n < 4; n++) begin
            half((n == 0) ? a : ~a, d[n], bw[n], 1'b1, (n == 0) ? 1'b0 : 1'b1);
        end
    endtask

    // Command plus seven more half periods, capturing bus after each
    task automatic read_burst(input logic [18:0] a, output logic [7:0][17:0] qs,
                              output logic [7:0] oes);
        for (int n = 0; n < 8; n++) begin
            half((n == 0) ? a : ~a, ~wdata, ~bw_n, (n == 0) ? 1'b0 : 1'b1, 1'b1);
            qs[n]  = seen_q;
            oes[n] = seen_oe_n;
        end
    endtask
endmodule

// ---- test_dual_port_burst_sram_port.sv ----
// Testbench for the burst memory port, 18-bit organisation
`timescale 1ns/10ps

module test_dual_port_burst_sram_port import dpbs_pkg::*; ;
    logic              sys_clk;
    logic              nrst;
    logic              k;
    logic              kb;
    logic [18:0]       addr;
    logic [17:0]       wdata;
    logic [1:0]        bw_n;
    logic              rps_n;
    logic              wps_n;
    logic [17:0]       q;
    logic              q_oe_n;
    logic [17:0]       mdl [int];
    int                fails;
    int                n_checks;

    dpbs_port #(.DATA_W(DPBS_ORG_W), .FIFO_DP(DPBS_FIFO_DEPTH)) i_dut (
        .sys_clk(sys_clk), .nrst(nrst), .primary_timing_input(k),
        .inverted_timing_input(kb), .addr_in(addr), .write_word_bus(wdata),
        .byte_lane_write_select_n(bw_n), .read_port_select_n(rps_n),
        .write_port_select_n(wps_n), .output_word_bus(q), .output_word_bus_oe_n(q_oe_n)
    );

    dpbs_ctl_model i_ctl (
        .sys_clk(sys_clk), .q(q), .q_oe_n(q_oe_n), .k(k), .kb(kb), .addr(addr),
        .wdata(wdata), .bw_n(bw_n), .rps_n(rps_n), .wps_n(wps_n)
    );

    always #10 sys_clk = ~sys_clk;

    task automatic chk(input string name, input logic [17:0] seen, input logic [17:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [18:0] a, input logic [3:0][17:0] d,
                      input logic [3:0][1:0] bw);
        i_ctl.write_burst(a, d, bw);
        for (int n = 0; n < 4; n++) begin
            for (int l = 0; l < 2; l++) begin
                if (bw[n][l] == 1'b0) mdl[int'(a) * 4 + n][l * 9 +: 9] = d[n][l * 9 +: 9];
            end
        end
    endtask

    task automatic rd(input logic [18:0] a);
        logic [7:0][17:0] qs;
        logic [7:0]       oes;
        i_ctl.read_burst(a, qs, oes);
        for (int n = 0; n < 8; n++) begin
            chk("oe_n", 18'(oes[n]), 18'((n < 2) || (n > 6)));
        end
        for (int n = 0; n < 4; n++) begin
            chk("rdata", qs[n + 2], mdl[int'(a) * 4 + n]);
        end
        chk("rdata_hold", qs[6], mdl[int'(a) * 4 + 3]);
    endtask

    // Released bus after reset
    task automatic t_reset();
        chk("oe_n_reset", 18'(q_oe_n), 18'h1);
        chk("q_reset", q, 18'h0);
    endtask

    // Full bursts at both ends of the address range
    task automatic t_full();
        wr(19'h7FFFF, {18'h2AAAA, 18'h15555, 18'h3FFFF, 18'h00001}, 8'h00);
        wr(19'h00000, {18'h0F0F0, 18'h30303, 18'h00000, 18'h12345}, 8'h00);
        rd(19'h7FFFF);
        rd(19'h00000);
    endtask

    // Per-beat lane masks merge with stored words
    task automatic t_lanes();
        wr(19'h2A5A5, {18'h11111, 18'h22222, 18'h33333, 18'h04444}, 8'h00);
        wr(19'h2A5A5, {18'h3C3C3, 18'h1E1E1, 18'h2D2D2, 18'h0B0B0}, 8'h3E);
        rd(19'h2A5A5);
    endtask

    // Deselected write port: address and data must be ignored
    task automatic t_desel();
        for (int n = 0; n < 4; n++) begin
            i_ctl.half(19'h2A5A5, 18'h3FFFF, 2'h0, 1'b1, 1'b1);
        end
        rd(19'h2A5A5);
    endtask

    initial begin
        sys_clk  = 1'b0;
        nrst     = 1'b0;
        fails    = 0;
        n_checks = 0;
        repeat (3) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        t_reset();
        t_full();
        t_lanes();
        t_desel();
        end_of_test();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        fails++;
        end_of_test();
    end
endmodule
